// ---- logic/usw_pkg.sv ----
// Package of constants for the two-wire serial interface block
package usw_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PINPOS = 4'h1;
    localparam logic [3:0] ADDR_DATA = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_PORT = 4'h4;
    // ************************************************************
    // Control fields
    // ************************************************************
    localparam int CTRL_TC = 0;
    localparam int CTRL_CLK = 1;
    localparam int CTRL_CS0 = 2;
    localparam int CTRL_CS1 = 3;
    localparam int CTRL_WM_LO = 4;
    localparam int CTRL_SIE = 7;
    // ************************************************************
    // Status fields
    // ************************************************************
    localparam int ST_SIF = 7;
    localparam int ST_OIF = 6;
    localparam int ST_PF = 5;
    localparam int ST_DC = 4;
    // Port register fields: dout, dir bits
    localparam int PORT_SDA = 0;
    localparam int PORT_DO = 1;
    localparam int PORT_SCL = 2;
    localparam int PORT_DIR_SDA = 4;
    localparam int PORT_DIR_DO = 5;
    localparam int PORT_DIR_SCL = 6;
    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [1:0] WM_OFF = 2'h0;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] CNT_MAX = 4'hf;
    localparam logic [3:0] CNT_ONE = 4'h1;
endpackage : usw_pkg

// ---- logic/usw_sync.sv ----
// Two-flop synchroniser for the serial pin inputs
`timescale 1ns/1ps
module usw_sync (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [2:0] async_in,
    output logic [2:0] sync_out
);
    logic [2:0] meta_r;

    // First stage is read only by the second
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            meta_r <= 3'h7;
            sync_out <= 3'h7;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : usw_sync

// ---- logic/usw_core.sv ----
// Two-wire serial interface: pins, clocking, counter and holds
//
// Overview of operation
// - Mode 10 makes SDA and SCL open-collector
// - SDA pulled low when shifter or port zero
// - SCL pulled low by port or start hold
// - Start holds SCL until start flag cleared
// - Two-wire modes disable SDA and SCL pull-ups
// - Mode 11 also holds SCL after overflow
// - External clock: three-wire DO updates opposite edge
// - Strobe or timer clock: latch transparent
// - Source 00/01 selects strobe or timer clock
// - External edge polarity; counter both or toggle
// - Strobe shifts register, bumps counter, reads zero
// - Strobe shifts in previously sampled input
// - External source: strobe bit stored as selector
// - Toggle bit inverts clock port, reads zero
// - Toggle with selector increments counter
// - Pin position upper seven bits read zero
// - Position bit routes pins B or A
// - Overflow flag on wrap, write-one clears
// - Mode 00 disables outputs, hold, detector
`timescale 1ns/1ps
module usw_core (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic timer0_match_in,
    input wire logic [2:0] portb_in,
    output logic [2:0] portb_out,
    output logic [2:0] portb_oe_out,
    output logic [2:0] portb_pullup_dis_out,
    input wire logic [2:0] porta_in,
    output logic [2:0] porta_out,
    output logic [2:0] porta_oe_out,
    output logic [2:0] porta_pullup_dis_out
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] ctrl_r;
    logic pos_r;
    logic [7:0] data_r;
    logic [3:0] cnt_r;
    logic sif_r;
    logic oif_r;
    logic pf_r;
    logic [6:0] port_r;
    logic out_latch_r;
    logic di_prev_r;
    logic scl_prev_r;
    logic sda_prev_r;
    logic [7:0] rdata_nxt;
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    logic sda_in_s;
    logic scl_in_s;
    logic [1:0] wm;
    logic [1:0] cs;
    logic wr_ctrl;
    logic strobe_wr;
    logic toggle_wr;
    logic ext_src;
    logic scl_rise;
    logic scl_fall;
    logic shift_ev;
    logic cnt_ev;
    logic cnt_wr;
    logic two_wire;
    logic start_det;
    logic stop_det;
    logic ovf_ev;
    logic sda_drive_low;
    logic scl_drive_low;
    logic sda_oe;
    logic scl_oe;
    logic do_val;

    // Address match shared by read and write paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction : hit

    assign wm = ctrl_r[usw_pkg::CTRL_WM_LO +: 2];
    assign cs = ctrl_r[usw_pkg::CTRL_CS0 +: 2];
    assign ext_src = ctrl_r[usw_pkg::CTRL_CS1];
    assign two_wire = wm[1];
    assign wr_ctrl = wr_in && hit(addr_in, usw_pkg::ADDR_CTRL);
    assign strobe_wr = wr_ctrl && wdata_in[usw_pkg::CTRL_CLK];
    assign toggle_wr = wr_ctrl && wdata_in[usw_pkg::CTRL_TC];
    assign cnt_wr = wr_in && hit(addr_in, usw_pkg::ADDR_STATUS);

    // ************************************************************
    // Pin routing and synchronisation
    // ************************************************************
    // Inputs: [0] data in, [1] data out pin, [2] clock
    assign pin_raw = pos_r ? porta_in : portb_in;

    usw_sync u_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    assign sda_in_s = pin_sync[0];
    assign scl_in_s = pin_sync[2];

    // Previous synchronised levels for edge detection
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
            di_prev_r <= 1'b1;
        end
        else
        begin
            scl_prev_r <= scl_in_s;
            sda_prev_r <= sda_in_s;
            di_prev_r <= sda_in_s;
        end
    end

    assign scl_rise = scl_in_s && !scl_prev_r;
    assign scl_fall = !scl_in_s && scl_prev_r;
    // Detector off in mode 00 and three-wire mode
    assign start_det = two_wire && scl_in_s && sda_prev_r
        && !sda_in_s;
    assign stop_det = two_wire && scl_in_s && !sda_prev_r && sda_in_s;

    // ************************************************************
    // Clock source selection
    // ************************************************************
    always_comb
    begin
        shift_ev = 1'b0;
        cnt_ev = 1'b0;
        if (ext_src)
        begin
            // Low select bit picks the sampling edge
            shift_ev = cs[0] ? scl_fall : scl_rise;
            if (ctrl_r[usw_pkg::CTRL_CLK])
                cnt_ev = toggle_wr;
            else
                cnt_ev = scl_rise || scl_fall;
        end
        else if (cs[0])
        begin
            shift_ev = timer0_match_in;
            cnt_ev = timer0_match_in;
        end
        else
        begin
            shift_ev = strobe_wr;
            cnt_ev = strobe_wr;
        end
    end

    // ************************************************************
    // Control, position and port registers
    // ************************************************************
    // Strobe bit kept only as selector under external source
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            ctrl_r <= usw_pkg::RST_BYTE;
        else if (wr_ctrl)
        begin
            ctrl_r <= wdata_in;
            ctrl_r[usw_pkg::CTRL_TC] <= 1'b0;
            ctrl_r[usw_pkg::CTRL_CLK] <= wdata_in[usw_pkg::CTRL_CS1]
                && wdata_in[usw_pkg::CTRL_CLK];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            pos_r <= 1'b0;
        else if (wr_in && hit(addr_in, usw_pkg::ADDR_PINPOS))
            pos_r <= wdata_in[0];
    end

    // Toggle inverts clock port bit whatever the direction
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            port_r <= 7'h00;
        else if (wr_in && hit(addr_in, usw_pkg::ADDR_PORT))
            port_r <= wdata_in[6:0];
        else if (toggle_wr)
            port_r[usw_pkg::PORT_SCL] <= !port_r[usw_pkg::PORT_SCL];
    end

    // ************************************************************
    // Shift register and output latch
    // ************************************************************
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            data_r <= usw_pkg::RST_BYTE;
        else if (wr_in && hit(addr_in, usw_pkg::ADDR_DATA))
            data_r <= wdata_in;
        else if (shift_ev)
            data_r <= {data_r[6:0], di_prev_r};
    end

    // Latch follows the opposite external edge to sampling
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            out_latch_r <= 1'b0;
        else if (cs[0] ? scl_rise : scl_fall)
            out_latch_r <= data_r[7];
    end

    // Transparent for strobe and timer sources
    assign do_val = ext_src ? out_latch_r : data_r[7];

    // ************************************************************
    // Counter and flags
    // ************************************************************
    assign ovf_ev = cnt_ev && (cnt_r == usw_pkg::CNT_MAX);

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            cnt_r <= 4'h0;
        else if (cnt_wr)
            cnt_r <= wdata_in[3:0];
        else if (cnt_ev)
            cnt_r <= cnt_r + usw_pkg::CNT_ONE;
    end

    // Set beats a simultaneous write-one clear
    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
        begin
            sif_r <= 1'b0;
            oif_r <= 1'b0;
            pf_r <= 1'b0;
        end
        else
        begin
            if (start_det)
                sif_r <= 1'b1;
            else if (cnt_wr && wdata_in[usw_pkg::ST_SIF])
                sif_r <= 1'b0;
            if (ovf_ev)
                oif_r <= 1'b1;
            else if (cnt_wr && wdata_in[usw_pkg::ST_OIF])
                oif_r <= 1'b0;
            if (stop_det)
                pf_r <= 1'b1;
            else if (cnt_wr && wdata_in[usw_pkg::ST_PF])
                pf_r <= 1'b0;
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    assign sda_oe = port_r[usw_pkg::PORT_DIR_SDA];
    assign scl_oe = port_r[usw_pkg::PORT_DIR_SCL];
    assign sda_drive_low = !data_r[7] || !port_r[usw_pkg::PORT_SDA];
    assign scl_drive_low = !port_r[usw_pkg::PORT_SCL] || sif_r
        || (wm == usw_pkg::WM_TWO_HOLD && oif_r);

    // Open collector: enable only while pulling low
    always_comb
    begin
        portb_out = 3'h0;
        portb_oe_out = 3'h0;
        porta_out = 3'h0;
        porta_oe_out = 3'h0;
        portb_pullup_dis_out = 3'h0;
        porta_pullup_dis_out = 3'h0;
        if (two_wire)
        begin
            portb_oe_out = {scl_oe && scl_drive_low,
                port_r[usw_pkg::PORT_DIR_DO],
                sda_oe && sda_drive_low};
            portb_out = {1'b0, port_r[usw_pkg::PORT_DO], 1'b0};
            portb_pullup_dis_out = 3'h5;
        end
        else if (wm == usw_pkg::WM_OFF)
        begin
            // Ordinary port pins in mode 00
            portb_oe_out = port_r[usw_pkg::PORT_DIR_SDA +: 3];
            portb_out = port_r[2:0];
        end
        else
        begin
            portb_oe_out = port_r[usw_pkg::PORT_DIR_SDA +: 3];
            portb_out = {port_r[usw_pkg::PORT_SCL], do_val,
                port_r[usw_pkg::PORT_SDA]};
        end
        if (pos_r)
        begin
            porta_out = portb_out;
            porta_oe_out = portb_oe_out;
            porta_pullup_dis_out = portb_pullup_dis_out;
            portb_out = 3'h0;
            portb_oe_out = 3'h0;
            portb_pullup_dis_out = 3'h0;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (hit(addr_in, usw_pkg::ADDR_CTRL))
            rdata_nxt = {ctrl_r[7:2], 2'h0};
        else if (hit(addr_in, usw_pkg::ADDR_PINPOS))
            rdata_nxt = {7'h00, pos_r};
        else if (hit(addr_in, usw_pkg::ADDR_DATA))
            rdata_nxt = data_r;
        else if (hit(addr_in, usw_pkg::ADDR_STATUS))
            rdata_nxt = {sif_r, oif_r, pf_r,
                two_wire && (data_r[7] != sda_in_s), cnt_r};
        else if (hit(addr_in, usw_pkg::ADDR_PORT))
            rdata_nxt = {1'b0, port_r};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (srst_in)
            rdata_out <= 8'h00;
        else if (rd_in)
            rdata_out <= rdata_nxt;
        else
            rdata_out <= 8'h00;
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_strobe_cnt;
        @(posedge core_clk_in) disable iff (srst_in)
        (strobe_wr && cs == 2'h0 && !cnt_wr)
            |=> cnt_r == $past(cnt_r) + 4'h1;
    endproperty
    a_strobe_cnt: assert property (p_strobe_cnt)
        else $error("strobe did not bump counter");

    property p_ovf_set;
        @(posedge core_clk_in) disable iff (srst_in)
        ovf_ev |=> oif_r;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set");

    property p_start_hold;
        @(posedge core_clk_in) disable iff (srst_in)
        (sif_r && two_wire && scl_oe && !pos_r) |-> portb_oe_out[2];
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("start hold missing on clock line");

    property p_ovf_hold;
        @(posedge core_clk_in) disable iff (srst_in)
        (oif_r && wm == 2'h3 && scl_oe && !pos_r) |-> portb_oe_out[2];
    endproperty
    a_ovf_hold: assert property (p_ovf_hold)
        else $error("overflow hold missing");

    property p_ctrl_rd;
        @(posedge core_clk_in) disable iff (srst_in)
        (rd_in && addr_in == 4'h0) |=> rdata_out[1:0] == 2'h0;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd)
        else $error("strobe bits read nonzero");

    property p_pos_rd;
        @(posedge core_clk_in) disable iff (srst_in)
        (rd_in && addr_in == 4'h1) |=> rdata_out[7:1] == 7'h00;
    endproperty
    a_pos_rd: assert property (p_pos_rd)
        else $error("reserved position bits nonzero");

    property p_toggle;
        @(posedge core_clk_in) disable iff (srst_in)
        (toggle_wr && !(wr_in && addr_in == 4'h4))
            |=> port_r[2] != $past(port_r[2]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle did not invert clock port");

    property p_off_pins;
        @(posedge core_clk_in) disable iff (srst_in)
        (wm == usw_pkg::WM_OFF) |-> (portb_pullup_dis_out == 3'h0
            && porta_pullup_dis_out == 3'h0);
    endproperty
    a_off_pins: assert property (p_off_pins)
        else $error("pull-ups disabled outside two-wire");

    c_strobe: cover property (@(posedge core_clk_in) strobe_wr);
    c_start: cover property (@(posedge core_clk_in) start_det);
    c_ovf: cover property (@(posedge core_clk_in) ovf_ev);
endmodule : usw_core

// ---- sim/usw_peer.sv ----
// Two-wire bus peer: pull-up wires, data pull-down and clock master
`timescale 1ns/1ps
module usw_peer (
    input wire logic [5:0] dev_out_in,
    input wire logic [5:0] dev_oe_in,
    input wire logic sda_low_in,
    output logic [5:0] wire_out
);
    logic scl_low_r = 1'b0;

    // ************************************************************
    // Wire levels
    // ************************************************************
    // Wired-AND of device drive, peer pull-downs and bus pull-ups
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            wire_out[i] = dev_oe_in[i] ? dev_out_in[i] : 1'b1;
        end
        wire_out[0] = wire_out[0] & ~sda_low_in;
        wire_out[3] = wire_out[3] & ~sda_low_in;
        wire_out[2] = wire_out[2] & ~scl_low_r;
        wire_out[5] = wire_out[5] & ~scl_low_r;
    end

    // ************************************************************
    // Clock bursts
    // ************************************************************
    // Clock stands high between bursts; odd start offset keeps phase free
    task automatic burst(input int n);
        #37;
        for (int i = 0; i < n; i++)
        begin
            scl_low_r = 1'b1;
            #100;
            scl_low_r = 1'b0;
            // Stretch: a held clock line delays our next low phase
            wait (wire_out[2] & wire_out[5]);
            #100;
        end
    endtask : burst
endmodule : usw_peer

// ---- sim/test_usw_core.sv ----
// Self-checking bench for the two-wire serial interface core
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    fail_count++; $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
    end end
module test_usw_core;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tmr = 1'b0;
    logic sda_low = 1'b0;
    logic [7:0] rdata, v;
    logic [2:0] pb_out, pb_oe, pb_pud, pa_out, pa_oe, pa_pud;
    logic [5:0] wires;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;

    // ************************************************************
    // Clock, design and peer
    // ************************************************************
    // 40 MHz core clock
    always #12.5 clk = ~clk;
    usw_core i_usw_core (.core_clk_in(clk), .srst_in(srst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .timer0_match_in(tmr), .portb_in(wires[2:0]), .portb_out(pb_out),
        .portb_oe_out(pb_oe), .portb_pullup_dis_out(pb_pud),
        .porta_in(wires[5:3]), .porta_out(pa_out), .porta_oe_out(pa_oe),
        .porta_pullup_dis_out(pa_pud));
    usw_peer i_usw_peer (.dev_out_in({pa_out, pb_out}),
        .dev_oe_in({pa_oe, pb_oe}), .sda_low_in(sda_low), .wire_out(wires));

    // ************************************************************
    // Bus tasks and closing
    // ************************************************************
    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rd_reg(usw_pkg::ADDR_CTRL, v);
        `CHK("ctrl", 8'h00, v)
        `CHK("oe_b", 3'b000, pb_oe)
        rd_reg(4'h9, v);
        `CHK("unmapped", 8'h00, v)
        wr_reg(usw_pkg::ADDR_PINPOS, 8'hfe);
        rd_reg(usw_pkg::ADDR_PINPOS, v);
        `CHK("pinpos", 8'h00, v)
    endtask : t_reset

    task automatic t_soft();
        wr_reg(usw_pkg::ADDR_DATA, 8'h5a);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h00);
        rd_reg(usw_pkg::ADDR_DATA, v);
        `CHK("no clock", 8'h5a, v)
        wr_reg(usw_pkg::ADDR_CTRL, 8'h02);
        rd_reg(usw_pkg::ADDR_DATA, v);
        `CHK("strobe shift", 8'hb5, v)
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("strobe cnt", 8'h01, v & 8'h0f)
        rd_reg(usw_pkg::ADDR_CTRL, v);
        `CHK("strobe reads", 8'h00, v)
    endtask : t_soft

    task automatic t_timer();
        wr_reg(usw_pkg::ADDR_STATUS, 8'h00);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h04);
        @(posedge clk);
        tmr <= 1'b1;
        @(posedge clk);
        tmr <= 1'b0;
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("timer cnt", 8'h01, v & 8'h0f)
        rd_reg(usw_pkg::ADDR_DATA, v);
        `CHK("timer shift", 8'h6b, v)
    endtask : t_timer

    task automatic t_twowire();
        wr_reg(usw_pkg::ADDR_PORT, 8'h55);
        wr_reg(usw_pkg::ADDR_DATA, 8'h40);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h20);
        `CHK("sda pull oe", 3'b001, pb_oe)
        `CHK("sda pull lvl", 1'b0, pb_out[0])
        `CHK("pullup off", 3'b101, pb_pud)
        wr_reg(usw_pkg::ADDR_CTRL, 8'h22);
        `CHK("sda at strobe", 1'b0, pb_oe[0])
        wr_reg(usw_pkg::ADDR_PORT, 8'h51);
        `CHK("scl port low", 3'b100, pb_oe)
        wr_reg(usw_pkg::ADDR_PORT, 8'h11);
        `CHK("scl no dir", 3'b000, pb_oe)
    endtask : t_twowire

    task automatic t_start();
        wr_reg(usw_pkg::ADDR_PORT, 8'h55);
        wr_reg(usw_pkg::ADDR_DATA, 8'hff);
        wr_reg(usw_pkg::ADDR_STATUS, 8'he0);
        sda_low <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK("start hold", 1'b1, pb_oe[2])
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("start flag", 8'h80, v & 8'h80)
        sda_low <= 1'b0;
        wr_reg(usw_pkg::ADDR_STATUS, 8'h80);
        `CHK("start free", 1'b0, pb_oe[2])
    endtask : t_start

    task automatic t_ovf();
        wr_reg(usw_pkg::ADDR_CTRL, 8'h30);
        wr_reg(usw_pkg::ADDR_STATUS, 8'hef);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h32);
        repeat (2) @(posedge clk);
        #1;
        `CHK("ovf hold", 1'b1, pb_oe[2])
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("ovf flag", 8'h40, v & 8'h4f)
        wr_reg(usw_pkg::ADDR_STATUS, 8'h40);
        `CHK("ovf free", 1'b0, pb_oe[2])
        wr_reg(usw_pkg::ADDR_CTRL, 8'h20);
        wr_reg(usw_pkg::ADDR_STATUS, 8'h0f);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h22);
        repeat (2) @(posedge clk);
        #1;
        `CHK("no ovf hold", 1'b0, pb_oe[2])
    endtask : t_ovf

    task automatic t_toggle();
        wr_reg(usw_pkg::ADDR_CTRL, 8'h00);
        wr_reg(usw_pkg::ADDR_PORT, 8'h04);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h01);
        rd_reg(usw_pkg::ADDR_PORT, v);
        `CHK("toggle no dir", 8'h00, v)
        `CHK("pin hidden", 1'b0, pb_oe[2])
        wr_reg(usw_pkg::ADDR_PORT, 8'h40);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h01);
        rd_reg(usw_pkg::ADDR_PORT, v);
        `CHK("toggle dir", 8'h44, v)
        `CHK("pin shown", 2'b11, {pb_oe[2], pb_out[2]})
        rd_reg(usw_pkg::ADDR_CTRL, v);
        `CHK("toggle reads", 8'h00, v)
    endtask : t_toggle

    task automatic t_ext();
        logic [7:0] cs [2] = '{8'h08, 8'h0c};
        wr_reg(usw_pkg::ADDR_PORT, 8'h00);
        // Both edge polarities: four clocks, data line released high
        foreach (cs[i])
        begin
            wr_reg(usw_pkg::ADDR_STATUS, 8'h00);
            wr_reg(usw_pkg::ADDR_DATA, 8'h00);
            wr_reg(usw_pkg::ADDR_CTRL, cs[i]);
            i_usw_peer.burst(4);
            repeat (6) @(posedge clk);
            rd_reg(usw_pkg::ADDR_STATUS, v);
            `CHK("ext both edges", 8'h08, v & 8'h0f)
            rd_reg(usw_pkg::ADDR_DATA, v);
            `CHK("ext shifts", 8'h0f, v)
        end
        wr_reg(usw_pkg::ADDR_CTRL, 8'h0a);
        wr_reg(usw_pkg::ADDR_STATUS, 8'h00);
        i_usw_peer.burst(2);
        repeat (6) @(posedge clk);
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("edges ignored", 8'h00, v & 8'h0f)
        repeat (3) wr_reg(usw_pkg::ADDR_CTRL, 8'h0b);
        rd_reg(usw_pkg::ADDR_STATUS, v);
        `CHK("toggle count", 8'h03, v & 8'h0f)
    endtask : t_ext

    task automatic t_pos();
        wr_reg(usw_pkg::ADDR_PINPOS, 8'h01);
        wr_reg(usw_pkg::ADDR_CTRL, 8'h20);
        wr_reg(usw_pkg::ADDR_DATA, 8'hff);
        wr_reg(usw_pkg::ADDR_PORT, 8'h51);
        `CHK("port a oe", 3'b100, pa_oe)
        `CHK("port a out", 3'b000, pa_out)
        `CHK("port b idle", 3'b000, pb_oe)
        `CHK("port a pullup", 3'b101, pa_pud)
        wr_reg(usw_pkg::ADDR_PINPOS, 8'h00);
        `CHK("port b oe", 3'b100, pb_oe)
    endtask : t_pos

    // ************************************************************
    // Main sequence
    // ************************************************************
    // Reset held for ten cycles, then every scenario in turn
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_soft();
        t_timer();
        t_twowire();
        t_start();
        t_ovf();
        t_toggle();
        t_ext();
        t_pos();
        close_out();
    end
endmodule : test_usw_core
